// ---- common/plcc_map.svh ----
/*
 * Offsets, field positions, reset values and ordered-set counts of the
 * link capability and link control block.
 * Assumes it is included by its bare name, before the package.
 */
`ifndef PLCC_MAP_SVH
`define PLCC_MAP_SVH

// ------------------------------------------------------------
// configuration offsets
// ------------------------------------------------------------
`define PLCC_OFS_CAP 8'hCC
`define PLCC_OFS_CTL 8'hD0

// ------------------------------------------------------------
// capability reset values
// ------------------------------------------------------------
`define PLCC_RST_SPEED 4'h2
`define PLCC_RST_WIDTH 6'h01
`define PLCC_RST_ASPM 2'h0
`define PLCC_RST_L0S 3'h3
`define PLCC_RST_L1 3'h0

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define PLCC_CTL_ASPM_L0S 0
`define PLCC_CTL_ASPM_L1 1
`define PLCC_CTL_RCB 3
`define PLCC_CTL_LDIS 4
`define PLCC_CTL_RETRAIN 5
`define PLCC_CTL_CCLK 6
`define PLCC_CTL_EXTSYN 7
`define PLCC_CTL_HAWD 9
`define PLCC_CTL_B10 10
`define PLCC_CTL_B11 11
// training flag position inside the upper half of the control word
`define PLCC_STS_TRAIN 11

// writable masks per port role
`define PLCC_WMASK_DN 16'h0ED3
`define PLCC_WMASK_UP 16'h02C3
`define PLCC_RST_CTL 16'h0000

// ------------------------------------------------------------
// ordered-set counts on exit from low power
// ------------------------------------------------------------
`define PLCC_FTS_EXT 13'h1000
`define PLCC_TS1_EXT 13'h0400
`define PLCC_FTS_NORM 13'h0080
`define PLCC_TS1_NORM 13'h0010

`endif

// ---- common/plcc_pkg.sv ----
/*
 * Types of the link capability and link control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package plcc_pkg;

	// capability word layout, msb first
	typedef struct packed {
		logic [7:0] port_num;
		logic [1:0] rsvd_hi;
		logic bw_notify;
		logic dll_rpt;
		logic [1:0] rsvd_lo;
		logic [2:0] l1_lat;
		logic [2:0] l0s_lat;
		logic [1:0] aspm_sup;
		logic [5:0] max_width;
		logic [3:0] max_speed;
	} plcc_cap_t;

	// retrain sequencer states
	typedef enum logic [1:0] {
		PLCC_IDLE,
		PLCC_REQ,
		PLCC_TRAIN
	} plcc_trn_t;

endpackage : plcc_pkg

// ---- common/plcc_trn_if.sv ----
/*
 * Carrier between the register bank and its retrain sequencer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns

interface plcc_trn_if;
	logic start; // one-cycle retrain request from software
	logic done; // training finished, from the link layer
	logic req; // one-cycle retrain pulse toward the link
	logic busy; // training in progress

	modport ctl (output start, output done, input req, input busy);
	modport trn (input start, input done, output req, output busy);
endinterface : plcc_trn_if

// ---- rtl/plcc_retrain.sv ----
/*
 * Retrain sequencer: turns a retrain write into a request pulse and
 * holds the training flag until the link reports completion.
 * Assumes done is a same-clock level or pulse from the link layer.
 */
`timescale 1ns/1ns

module plcc_retrain (
	input wire logic clk_sys,
	input wire logic sys_rst,
	plcc_trn_if.trn trn
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	plcc_pkg::plcc_trn_t state_reg; // sequencer state
	logic req_reg; // request pulse
	logic busy_reg; // training flag

	assign trn.req = req_reg;
	assign trn.busy = busy_reg;

	// state walk; a new start beats a done in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			state_reg <= plcc_pkg::PLCC_IDLE;
		else if (trn.start)
			state_reg <= plcc_pkg::PLCC_REQ;
		else
		begin
			unique case (state_reg)
				plcc_pkg::PLCC_IDLE: state_reg <= plcc_pkg::PLCC_IDLE;
				plcc_pkg::PLCC_REQ: state_reg <= plcc_pkg::PLCC_TRAIN;
				plcc_pkg::PLCC_TRAIN:
				begin
					if (trn.done)
						state_reg <= plcc_pkg::PLCC_IDLE;
				end
				default: state_reg <= plcc_pkg::PLCC_IDLE;
			endcase
		end
	end

	// request pulse lasts exactly one cycle after the write
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			req_reg <= 1'b0;
		else
			req_reg <= trn.start;
	end

	// training flag: set wins over the clear by done
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			busy_reg <= 1'b0;
		else if (trn.start)
			busy_reg <= 1'b1;
		else if (trn.done && state_reg == plcc_pkg::PLCC_TRAIN)
			busy_reg <= 1'b0;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_start;
		trn.start;
	endsequence

	chk_trn_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_start |=> busy_reg && req_reg)
		else $error("training flag or request missing after retrain");

	chk_trn_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(state_reg == plcc_pkg::PLCC_TRAIN && trn.done && !trn.start) |=> !busy_reg)
		else $error("training flag not cleared on done");

endmodule : plcc_retrain

// ---- rtl/plcc_regs.sv ----
/*
 * Per-port link capability word and link control half-word of a
 * four-port switch, with its configuration read/write port, the
 * side-band override load and the retrain sequencer.
 * Assumes configuration requests, override loads and link-layer
 * status all come from logic on clk_sys; PORT_ID 0 is the upstream port.
 */
`timescale 1ns/1ns
`include "plcc_map.svh"

// How it works
// - max speed reads bits 3:0, resets 5 GT/s
// - max width bits 9:4, resets single lane
// - ASPM support bits 11:10, resets zero, overridable
// - L0s exit code bits 14:12, resets 011
// - L1 exit code bits 17:15, resets 000
// - DLL-active bit: upstream zero, downstream from hot-plug or support
// - bandwidth notify: upstream zero, downstream one
// - port number bits 31:24, resets to index
// - ASPM control bits 1:0 enable L0s/L1
// - receiver always allowed to enter L0s
// - completion boundary bit always reads zero
// - link disable: upstream fixed zero, downstream works
// - retrain: upstream zero, downstream starts, reads zero
// - common clock bit writable, resets zero
// - extended synch selects 4096 FTS, 1024 TS1
// - autonomous width disable writable, resets zero
// - bits 10, 11 writable downstream only
// - training flag set during training, hardware clears

module plcc_regs #(
	parameter logic [1:0] PORT_ID = 2'h0
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rd_valid,
	input wire logic ovr_load,
	input wire logic [31:0] ovr_data,
	input wire logic hp_capable,
	input wire logic dll_rpt_support,
	input wire logic train_done,
	output logic [31:0] cap_word,
	output logic aspm_l0s_en,
	output logic aspm_l1_en,
	output logic rx_l0s_allow,
	output logic link_disable,
	output logic common_clk,
	output logic ext_synch,
	output logic hw_aw_disable,
	output logic ctl_bit10,
	output logic ctl_bit11,
	output logic retrain_req,
	output logic link_training,
	output logic [12:0] fts_count,
	output logic [12:0] ts1_count
);

	// ------------------------------------------------------------
	// port role
	// ------------------------------------------------------------
	// the upstream port may neither disable nor retrain its link
	localparam logic UPSTREAM = (PORT_ID == 2'h0);
	localparam logic [15:0] WMASK = UPSTREAM ? `PLCC_WMASK_UP : `PLCC_WMASK_DN;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	plcc_pkg::plcc_cap_t cap_reg; // capability word
	logic [15:0] ctl_reg; // only writable bits are ever set here
	logic [15:0] ctl_next; // control after a write
	logic [15:0] be_mask; // byte lanes of the current write
	logic [31:0] rdata_reg; // read answer
	logic [31:0] rdata_next; // read mux
	logic rd_valid_reg; // read answer strobe
	logic l0s_allow_reg; // receiver L0s permission
	logic [12:0] fts_reg; // FTS sets on L0s exit
	logic [12:0] ts1_reg; // TS1 sets on L1 exit
	logic wr_ctl; // write hits the control word
	logic wr_cap; // write hits the capability word

	plcc_trn_if trn_bus ();

	assign wr_ctl = cfg_wr && (cfg_addr == `PLCC_OFS_CTL);
	assign wr_cap = cfg_wr && (cfg_addr == `PLCC_OFS_CAP);

	// ------------------------------------------------------------
	// capability word
	// ------------------------------------------------------------
	// software writes never touch this word; only reset, the side-band
	// override and, for dll_rpt, hp_capable and dll_rpt_support change it;
	// width is not overridable; one process owns the whole word, so no field has two drivers
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cap_reg.max_speed <= `PLCC_RST_SPEED;
			cap_reg.max_width <= `PLCC_RST_WIDTH;
			cap_reg.aspm_sup <= `PLCC_RST_ASPM;
			cap_reg.l0s_lat <= `PLCC_RST_L0S;
			cap_reg.l1_lat <= `PLCC_RST_L1;
			cap_reg.rsvd_lo <= 2'h0;
			cap_reg.rsvd_hi <= 2'h0;
			cap_reg.port_num <= {6'h00, PORT_ID};
			cap_reg.dll_rpt <= 1'b0;
			cap_reg.bw_notify <= !UPSTREAM;
		end
		else
		begin
			if (ovr_load)
			begin
				// override from the management bus or the eeprom loader
				cap_reg.max_speed <= ovr_data[3:0];
				cap_reg.aspm_sup <= ovr_data[11:10];
				cap_reg.l0s_lat <= ovr_data[14:12];
				cap_reg.l1_lat <= ovr_data[17:15];
				cap_reg.port_num <= ovr_data[31:24];
			end
			// link-state bits follow the port role, never software;
			// upstream stays zero, downstream tracks its abilities
			cap_reg.dll_rpt <= !UPSTREAM && (hp_capable || dll_rpt_support);
			cap_reg.bw_notify <= !UPSTREAM;
		end
	end

	// ------------------------------------------------------------
	// control half-word
	// ------------------------------------------------------------
	// the mask keeps hardwired, read-only and reserved bits at zero
	always_comb
	begin
		be_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
		ctl_next = (ctl_reg & ~(be_mask & WMASK)) | (cfg_wdata[15:0] & be_mask & WMASK);
	end

	// one process for all writable control fields
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			ctl_reg <= `PLCC_RST_CTL;
		else if (wr_ctl)
			ctl_reg <= ctl_next;
	end

	// retrain is a write-only trigger on downstream ports
	assign trn_bus.start = wr_ctl && cfg_be[0] && cfg_wdata[`PLCC_CTL_RETRAIN] && !UPSTREAM;
	assign trn_bus.done = train_done;

	plcc_retrain u_retrain (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.trn(trn_bus.trn)
	);

	// ------------------------------------------------------------
	// low-power exit behaviour
	// ------------------------------------------------------------
	// receiver L0s is never gated by the ASPM control field
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			l0s_allow_reg <= 1'b1;
		else
			l0s_allow_reg <= 1'b1;
	end

	// ordered-set counts; one cycle behind the control bit
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			fts_reg <= `PLCC_FTS_NORM;
			ts1_reg <= `PLCC_TS1_NORM;
		end
		else if (ctl_reg[`PLCC_CTL_EXTSYN])
		begin
			fts_reg <= `PLCC_FTS_EXT;
			ts1_reg <= `PLCC_TS1_EXT;
		end
		else
		begin
			fts_reg <= `PLCC_FTS_NORM;
			ts1_reg <= `PLCC_TS1_NORM;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// unmapped offsets read zero; the retrain and completion
	// boundary bits are never stored, so they read zero as well
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		unique case (cfg_addr)
			`PLCC_OFS_CAP: rdata_next = cap_reg;
			`PLCC_OFS_CTL:
			begin
				rdata_next[15:0] = ctl_reg;
				rdata_next[16 + `PLCC_STS_TRAIN] = trn_bus.busy;
			end
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// answer one cycle after the read request
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rdata_reg <= 32'h0000_0000;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			rd_valid_reg <= cfg_rd;
			if (cfg_rd)
				rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// outputs, each a flop
	// ------------------------------------------------------------
	assign cfg_rdata = rdata_reg;
	assign cfg_rd_valid = rd_valid_reg;
	assign cap_word = cap_reg;
	assign aspm_l0s_en = ctl_reg[`PLCC_CTL_ASPM_L0S];
	assign aspm_l1_en = ctl_reg[`PLCC_CTL_ASPM_L1];
	assign rx_l0s_allow = l0s_allow_reg;
	assign link_disable = ctl_reg[`PLCC_CTL_LDIS];
	assign common_clk = ctl_reg[`PLCC_CTL_CCLK];
	assign ext_synch = ctl_reg[`PLCC_CTL_EXTSYN];
	assign hw_aw_disable = ctl_reg[`PLCC_CTL_HAWD];
	assign ctl_bit10 = ctl_reg[`PLCC_CTL_B10];
	assign ctl_bit11 = ctl_reg[`PLCC_CTL_B11];
	assign retrain_req = trn_bus.req;
	assign link_training = trn_bus.busy;
	assign fts_count = fts_reg;
	assign ts1_count = ts1_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_ctl_read;
		cfg_rd && cfg_addr == `PLCC_OFS_CTL;
	endsequence

	sequence s_after_reset;
		$fell(sys_rst);
	endsequence

	chk_cap_reset: assert property (@(posedge clk_sys)
		s_after_reset |-> cap_reg.max_speed == `PLCC_RST_SPEED && cap_reg.max_width ==
			`PLCC_RST_WIDTH && cap_reg.l0s_lat == `PLCC_RST_L0S &&
			cap_reg.l1_lat == `PLCC_RST_L1 && cap_reg.aspm_sup == `PLCC_RST_ASPM)
		else $error("capability reset value wrong");

	chk_port_reset: assert property (@(posedge clk_sys)
		s_after_reset |-> cap_reg.port_num == {6'h00, PORT_ID})
		else $error("port number reset value wrong");

	chk_cap_ro: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr_cap && !ovr_load) |=> $stable(cap_reg[17:0]) && $stable(cap_reg[31:24]))
		else $error("capability word changed by a software write");

	chk_dll_role: assert property (@(posedge clk_sys) disable iff (sys_rst)
		##1 cap_reg.dll_rpt == (!UPSTREAM && $past(hp_capable || dll_rpt_support)))
		else $error("dll active reporting bit wrong for role");

	chk_bw_role: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cap_reg.bw_notify == !UPSTREAM)
		else $error("bandwidth notify bit wrong for role");

	chk_ctl_rdzero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_ctl_read |=> !cfg_rdata[`PLCC_CTL_RCB] && !cfg_rdata[`PLCC_CTL_RETRAIN] && cfg_rd_valid)
		else $error("completion boundary or retrain bit read nonzero");

	chk_aspm_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr_ctl && cfg_be[0]) |=> {aspm_l1_en, aspm_l0s_en} == $past(cfg_wdata[1:0]))
		else $error("aspm control did not take the written value");

	chk_up_fixed: assert property (@(posedge clk_sys) disable iff (sys_rst)
		UPSTREAM |-> !link_disable && !retrain_req && !ctl_bit10 && !ctl_bit11)
		else $error("upstream port shows a downstream-only control");

	chk_l0s_allow: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rx_l0s_allow)
		else $error("receiver l0s permission dropped");

	chk_ext_synch: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ext_synch [*2] |-> fts_count == `PLCC_FTS_EXT && ts1_count == `PLCC_TS1_EXT)
		else $error("extended synch counts wrong");

	chk_retrain_req: assert property (@(posedge clk_sys) disable iff (sys_rst)
		trn_bus.start |=> retrain_req ##1 (!retrain_req || $past(trn_bus.start)))
		else $error("retrain request pulse wrong");

endmodule : plcc_regs

// ---- verification/plcc_link_model.sv ----
/*
 * Link-layer stand-in for the retrain sequencer: answers each retrain
 * pulse with a one-cycle training-done pulse after a chosen delay.
 * Assumes retrain_req is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/1ns

module plcc_link_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic retrain_req,
	input wire logic [7:0] delay,
	output logic train_done
);
	// cycles left before training ends, zero when idle
	int unsigned left_reg = 0;
	// done pulse, low from time zero so the design never sees an unknown
	logic done_reg = 1'b0;

	assign train_done = done_reg;

	// a new request restarts the count, as a real link restarts training
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			left_reg <= 0;
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= (left_reg == 1);
			if (retrain_req)
				left_reg <= (delay == 8'h00) ? 1 : delay;
			else if (left_reg != 0)
				left_reg <= left_reg - 1;
		end
	end
endmodule : plcc_link_model

// ---- verification/test_plcc_regs.sv ----
/*
 * Self-checking bench: an upstream (index 0) and a downstream port
 * (index 1, port 2) share all stimulus; outputs are judged per port.
 * Assumes the design files and plcc_link_model are compiled first.
 */
`timescale 1ns/1ns

module test_plcc_regs;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic clk_sys, sys_rst, cfg_wr, cfg_rd, ovr_load, hp_capable, dll_rpt_support, train_done;
	logic [7:0] cfg_addr, delay;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, ovr_data;
	logic [31:0] rdata [2], cap [2];
	logic vld [2], l0s [2], l1 [2], rxl0s [2], ldis [2], cclk [2], esyn [2], hawd [2];
	logic b10 [2], b11 [2], rreq [2], trn [2];
	logic [12:0] fts [2], ts1 [2];
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;

	// 250 MHz core clock
	always #2 clk_sys = ~clk_sys;

	// index 0 upstream, index 1 downstream
	for (genvar g = 0; g < 2; g++)
	begin : port_g
		plcc_regs #(.PORT_ID(g == 0 ? 2'h0 : 2'h2)) DUT (
			.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
			.cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(rdata[g]),
			.cfg_rd_valid(vld[g]), .ovr_load(ovr_load), .ovr_data(ovr_data),
			.hp_capable(hp_capable), .dll_rpt_support(dll_rpt_support),
			.train_done(train_done), .cap_word(cap[g]), .aspm_l0s_en(l0s[g]),
			.aspm_l1_en(l1[g]), .rx_l0s_allow(rxl0s[g]), .link_disable(ldis[g]),
			.common_clk(cclk[g]), .ext_synch(esyn[g]), .hw_aw_disable(hawd[g]),
			.ctl_bit10(b10[g]), .ctl_bit11(b11[g]), .retrain_req(rreq[g]),
			.link_training(trn[g]), .fts_count(fts[g]), .ts1_count(ts1[g])
		);
	end

	// the far side only sees the downstream port's retrain pulse
	plcc_link_model link (.clk_sys(clk_sys), .sys_rst(sys_rst), .retrain_req(rreq[1]),
		.delay(delay), .train_done(train_done));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic print_verdict;
		$display("checked %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one-cycle write strobe; returns just after the taking edge
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk_sys);
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		cfg_wr <= 1'b1;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
		#1;
	endtask : wr

	// one-cycle read strobe; valid stands only in the cycle after the taking edge
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		cfg_addr <= a;
		cfg_rd <= 1'b1;
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
		#1;
		chk("valid up", 32'h1, 32'(vld[0]));
		chk("valid dn", 32'h1, 32'(vld[1]));
	endtask : rd

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		@(posedge clk_sys);
		#1;
		chk("cap up", 32'h0000_3012, cap[0]);
		chk("cap dn", 32'h0220_3012, cap[1]);
		chk("rx l0s", 32'h1, 32'(rxl0s[1]));
		chk("fts", 32'h80, 32'(fts[1]));
		chk("ts1", 32'h10, 32'(ts1[1]));
		rd(8'hD0);
		chk("ctl up", 32'h0, rdata[0]);
		chk("ctl dn", 32'h0, rdata[1]);
		$display("test reset done");
	endtask : t_reset

	// every writable bit set (retrain aside); upstream keeps its fixed bits low
	task automatic t_ctl;
		wr(8'hD0, 4'h3, 32'h0000_FFDF);
		chk("ldis up", 32'h0, 32'(ldis[0]));
		chk("ldis dn", 32'h1, 32'(ldis[1]));
		chk("b11 up", 32'h0, 32'(b11[0]));
		chk("b10 up", 32'h0, 32'(b10[0]));
		chk("b10 dn", 32'h1, 32'(b10[1]));
		chk("b11 dn", 32'h1, 32'(b11[1]));
		chk("cclk up", 32'h1, 32'(cclk[0]));
		chk("cclk dn", 32'h1, 32'(cclk[1]));
		chk("hawd up", 32'h1, 32'(hawd[0]));
		chk("hawd dn", 32'h1, 32'(hawd[1]));
		chk("esyn up", 32'h1, 32'(esyn[0]));
		chk("esyn dn", 32'h1, 32'(esyn[1]));
		@(posedge clk_sys);
		#1;
		chk("fts ext", 32'h1000, 32'(fts[1]));
		chk("ts1 ext", 32'h400, 32'(ts1[1]));
		rd(8'hD0);
		chk("ctl up", 32'h02C3, rdata[0]);
		chk("ctl dn", 32'h0ED3, rdata[1]);
		// high byte only: low byte must survive
		wr(8'hD0, 4'h2, 32'h0);
		chk("hawd clr", 32'h0, 32'(hawd[1]));
		chk("b11 clr", 32'h0, 32'(b11[1]));
		chk("esyn kept", 32'h1, 32'(esyn[1]));
		wr(8'hCC, 4'hF, 32'h0);
		rd(8'hD0);
		chk("ctl be dn", 32'h00D3, rdata[1]);
		rd(8'hCC);
		chk("cap ro", 32'h0220_3012, rdata[1]);
		rd(8'h40);
		chk("unmapped", 32'h0, rdata[1]);
		// all four entry codes, receiver L0s always allowed
		for (int c = 0; c < 4; c++)
		begin
			wr(8'hD0, 4'h1, 32'(c));
			chk("l0s en", 32'(c % 2), 32'(l0s[1]));
			chk("l1 en", 32'(c / 2), 32'(l1[0]));
			chk("rx l0s", 32'h1, 32'(rxl0s[0]));
		end
		chk("esyn off", 32'h0, 32'(esyn[1]));
		chk("fts norm", 32'h80, 32'(fts[1]));
		$display("test control done");
	endtask : t_ctl

	task automatic t_ovr;
		@(posedge clk_sys);
		ovr_data <= 32'hFFFF_FFFF;
		ovr_load <= 1'b1;
		@(posedge clk_sys);
		ovr_load <= 1'b0;
		#1;
		chk("ovr up", 32'hFF03_FC1F, cap[0]);
		chk("ovr dn", 32'hFF23_FC1F, cap[1]);
		// hot-plug, then reporting support, then neither
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk_sys);
			hp_capable <= (k == 0);
			dll_rpt_support <= (k == 1);
			repeat (2) @(posedge clk_sys);
			#1;
			chk("dll up", 32'hFF03_FC1F, cap[0]);
			chk("dll dn", k < 2 ? 32'hFF33_FC1F : 32'hFF23_FC1F, cap[1]);
		end
		// a second reset in mid-run must bring back every default
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("rst up", 32'h0000_3012, cap[0]);
		chk("rst dn", 32'h0220_3012, cap[1]);
		chk("rst l0s", 32'h0, 32'(l0s[1]));
		$display("test override done");
	endtask : t_ovr

	// prompt partner first, then a slow one read back in mid-training
	task automatic t_retrain;
		int n;
		for (int k = 0; k < 2; k++)
		begin
			delay <= (k == 0) ? 8'h02 : 8'h28;
			wr(8'hD0, 4'h1, 32'h20);
			chk("req dn", 32'h1, 32'(rreq[1]));
			chk("trn dn", 32'h1, 32'(trn[1]));
			chk("req up", 32'h0, 32'(rreq[0]));
			chk("trn up", 32'h0, 32'(trn[0]));
			@(posedge clk_sys);
			#1;
			chk("req pulse", 32'h0, 32'(rreq[1]));
			if (k == 1)
			begin
				rd(8'hD0);
				chk("ctl trn", 32'h0800_0000, rdata[1]);
			end
			n = 0;
			while (trn[1] !== 1'b0 && n < 100)
			begin
				@(posedge clk_sys);
				#1;
				n++;
			end
			chk("trn clear", 32'h0, 32'(trn[1]));
			rd(8'hD0);
			chk("ctl after", 32'h0, rdata[1]);
		end
		$display("test retrain done");
	endtask : t_retrain

	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			$display("ERROR timeout expected finish seen %0d cycles", cycles);
			print_verdict();
		end
	end

	initial
	begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		{cfg_wr, cfg_rd, ovr_load, hp_capable, dll_rpt_support} = 5'h00;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
		ovr_data = 32'h0;
		delay = 8'h02;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_ctl();
		t_ovr();
		t_retrain();
		print_verdict();
	end
endmodule : test_plcc_regs
